// File: aopra_channel.sv
// Per-channel parameter registers, register access, calibration and watchdog of an analog output
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// [R1] Offset trim low byte held; loaded to pot after reset and on its write.
// [R2] Gain trim low byte held; loaded to pot after reset and offset trim write.
// [R3] Manufacturer offset resets 0x0000, gain 0x0020 with 8 fraction bits.
// [R4] Reset or 100 ms watchdog timeout drives manufacturer switch-on value when selected.
// [R5] Parameter writes need key 0x1235; any other key value relocks.
// [R6] Key register reads back the key when unlocked, zero when locked.
// [R7] Mode config resets 0x0006; bit0 user scaling, bit1 maker scaling; reserved kept.
// [R8] Bit2 enables watchdog; timeout drives selected switch-on value.
// [R9] Bit3 reads output data as sign and magnitude.
// [R10] Bit5 takes absolute value, 0x7FFF and 0x8000 give full scale.
// [R11] Bit8 selects user switch-on value, clear selects manufacturer one.
// [R12] User offset resets 0x0000, gain 0x0100; used only when bit0 set.
// [R13] User switch-on value drives output after reset or timeout when selected.
// [R14] Process mode: bit6 enables compensation, bit4 gain cal, bit3 offset cal.
// [R15] Calibration steps trim up on bit1, down on bit0, 1000 ms or 50 ms.
// [R16] Calibration only while unlocked; save requested when key is cleared after a calibration step.
// [R17] Status byte carries nothing in process mode.
// [R18] Control bit7 set makes the data word register transfer data.
// [R19] Read returns addressed register unchanged.
// [R20] Write stores data word into addressed register, then acknowledges.
// [R21] Control bits 0 to 5 index 64 registers.
// [R22] Control or status byte is lowest byte, word follows.
// [R23] Read acknowledge echoes control byte in status byte.
// [R24] Write acknowledge is control byte with bit6 cleared; data invalid.
// [R25] Watchdog restarts on each process data cycle, flags timeout once.
module aopra_channel
	import aopra_pkg::*;
#(
	parameter int WDT_CYCLES       = WDT_CYC,
	parameter int STEP_SLOW_CYCLES = STEP_SLOW_CYC,
	parameter int STEP_FAST_CYCLES = STEP_FAST_CYC,
	parameter logic [7:0] HW_TRIM_RESET = RST_HW_TRIM
)(
	input  wire logic        core_clk_in,
	input  wire logic        rstn_in,
	input  wire logic        cycle_valid_in,
	input  wire logic [7:0]  channel_control_byte_in,
	input  wire logic [15:0] ctrl_data_word_in,
	output logic             cycle_done_out,
	output logic [7:0]       channel_status_byte_out,
	output logic [15:0]      stat_data_word_out,
	output logic [15:0]      output_value_out,
	output logic             default_active_out,
	output logic [7:0]       offset_pot_out,
	output logic             offset_pot_load_out,
	output logic [7:0]       gain_pot_out,
	output logic             gain_pot_load_out,
	output logic [15:0]      mode_config_out,
	output logic [15:0]      mfr_scale_offset_out,
	output logic [15:0]      mfr_scale_gain_out,
	output logic [15:0]      user_scale_offset_out,
	output logic [15:0]      user_scale_gain_out,
	output logic             unlocked_out,
	output logic             save_req_out
);

	////////////////////////////////////////////////////////////////////////////////
	// Decode of the incoming cycle
	logic       reg_cycle;
	logic       pd_cycle;
	logic       wr_cycle;
	logic [5:0] register_index;
	logic       unlocked;
	logic       wr_param;
	logic [15:0] unlock_key_reg;

	assign reg_cycle      = cycle_valid_in & channel_control_byte_in[CTL_REG_MODE]; // [R18]
	assign pd_cycle       = cycle_valid_in & ~channel_control_byte_in[CTL_REG_MODE]; // [R14]
	assign wr_cycle       = reg_cycle & channel_control_byte_in[CTL_WRITE]; // [R20]
	assign register_index = channel_control_byte_in[5:0]; // [R21]
	assign unlocked       = (unlock_key_reg == UNLOCK_CODE);
	assign wr_param       = wr_cycle & unlocked; // [R5]

	////////////////////////////////////////////////////////////////////////////////
	// Parameter registers
	logic [15:0] mode_config_reg;
	logic [15:0] mfr_scale_offset_reg;
	logic [15:0] mfr_scale_gain_reg;
	logic [15:0] mfr_default_output_reg;
	logic [15:0] user_scale_offset_reg;
	logic [15:0] user_scale_gain_reg;
	logic [15:0] user_default_output_reg;
	logic [7:0]  hw_offset_trim_reg;
	logic [7:0]  hw_gain_trim_reg;

	// Key register is always writable, so it can lock and unlock
	always_ff @(posedge core_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			unlock_key_reg <= 16'h0000;
		else if (wr_cycle && register_index == IDX_UNLOCK_KEY)
			unlock_key_reg <= ctrl_data_word_in; // [R5]
	end

	// Scaling, switch-on and mode registers, guarded by the key
	always_ff @(posedge core_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			mode_config_reg         <= RST_MODE_CONFIG; // [R7]
			mfr_scale_offset_reg    <= RST_MFR_OFFSET; // [R3]
			mfr_scale_gain_reg      <= RST_MFR_GAIN; // [R3]
			mfr_default_output_reg  <= RST_MFR_DEFAULT; // [R4]
			user_scale_offset_reg   <= RST_USER_OFFSET; // [R12]
			user_scale_gain_reg     <= RST_USER_GAIN; // [R12]
			user_default_output_reg <= RST_USER_DEFAULT; // [R13]
		end
		else if (wr_param)
		begin
			unique case (register_index)
				IDX_MODE_CONFIG:      mode_config_reg <= (ctrl_data_word_in & MODE_WRITABLE_MASK)
				                          | (mode_config_reg & ~MODE_WRITABLE_MASK); // [R7]
				IDX_MFR_SCALE_OFFSET: mfr_scale_offset_reg <= ctrl_data_word_in;
				IDX_MFR_SCALE_GAIN:   mfr_scale_gain_reg <= ctrl_data_word_in;
				IDX_MFR_DEFAULT_OUT:  mfr_default_output_reg <= ctrl_data_word_in;
				IDX_USER_SCALE_OFFSET: user_scale_offset_reg <= ctrl_data_word_in;
				IDX_USER_SCALE_GAIN:  user_scale_gain_reg <= ctrl_data_word_in;
				IDX_USER_DEFAULT_OUT: user_default_output_reg <= ctrl_data_word_in;
				default:              ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Calibration stepping of the hardware trims
	logic [7:0]       cal_ctrl_reg;
	logic [CNT_W-1:0] step_cnt_reg;
	logic             cal_active;
	logic             cal_step;
	logic             cal_dir_ok;
	logic [CNT_W-1:0] step_period;

	assign cal_dir_ok  = cal_ctrl_reg[CTL_UP] ^ cal_ctrl_reg[CTL_DOWN];
	assign cal_active  = unlocked & cal_ctrl_reg[CTL_COMP_EN] & cal_dir_ok
	                     & (cal_ctrl_reg[CTL_GAIN_CAL] | cal_ctrl_reg[CTL_OFFSET_CAL]); // [R14] [R16]
	assign step_period = cal_ctrl_reg[CTL_FAST] ? CNT_W'(STEP_FAST_CYCLES - 1)
	                                            : CNT_W'(STEP_SLOW_CYCLES - 1); // [R15]
	assign cal_step    = cal_active && (step_cnt_reg >= step_period);

	// Last process-mode control byte steers calibration
	always_ff @(posedge core_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			cal_ctrl_reg <= 8'h00;
		else if (pd_cycle)
			cal_ctrl_reg <= channel_control_byte_in; // [R14]
	end

	// Step period timer, idle while calibration is off
	always_ff @(posedge core_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			step_cnt_reg <= '0;
		else if (!cal_active || cal_step)
			step_cnt_reg <= '0;
		else
			step_cnt_reg <= step_cnt_reg + 1'b1; // [R15]
	end

	// Saturating one-step change of a trim value
	function automatic logic [7:0] trim_step(input logic [7:0] v, input logic up);
		if (up)
			trim_step = (v == 8'hFF) ? v : v + 8'h01;
		else
			trim_step = (v == 8'h00) ? v : v - 8'h01;
	endfunction

	// Trims: register writes take priority over calibration steps
	always_ff @(posedge core_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			hw_offset_trim_reg <= HW_TRIM_RESET;
			hw_gain_trim_reg   <= HW_TRIM_RESET;
		end
		else if (wr_param && register_index == IDX_HW_OFFSET_TRIM)
			hw_offset_trim_reg <= ctrl_data_word_in[7:0]; // [R1]
		else if (wr_param && register_index == IDX_HW_GAIN_TRIM)
			hw_gain_trim_reg <= ctrl_data_word_in[7:0]; // [R2]
		else if (cal_step)
		begin
			if (cal_ctrl_reg[CTL_OFFSET_CAL])
				hw_offset_trim_reg <= trim_step(hw_offset_trim_reg, cal_ctrl_reg[CTL_UP]); // [R15]
			if (cal_ctrl_reg[CTL_GAIN_CAL])
				hw_gain_trim_reg <= trim_step(hw_gain_trim_reg, cal_ctrl_reg[CTL_UP]); // [R15]
		end
	end

	// Pending permanent save: a new step wins over the relock that clears it
	logic cal_dirty_reg;
	logic relock;

	assign relock = wr_cycle && register_index == IDX_UNLOCK_KEY && ctrl_data_word_in != UNLOCK_CODE;

	always_ff @(posedge core_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			cal_dirty_reg <= 1'b0;
		else if (cal_step)
			cal_dirty_reg <= 1'b1;
		else if (relock)
			cal_dirty_reg <= 1'b0; // [R16]
	end

	always_ff @(posedge core_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			save_req_out <= 1'b0;
		else
			save_req_out <= relock & cal_dirty_reg; // [R16]
	end

	////////////////////////////////////////////////////////////////////////////////
	// Potentiometer transfers after reset, offset trim write or calibration step
	logic boot_reg;

	always_ff @(posedge core_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			boot_reg <= 1'b1;
		else
			boot_reg <= 1'b0;
	end

	always_ff @(posedge core_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			offset_pot_load_out <= 1'b0;
			gain_pot_load_out   <= 1'b0;
			offset_pot_out      <= 8'h00;
			gain_pot_out        <= 8'h00;
		end
		else
		begin
			offset_pot_load_out <= boot_reg | (wr_param && register_index == IDX_HW_OFFSET_TRIM)
			                       | (cal_step & cal_ctrl_reg[CTL_OFFSET_CAL]); // [R1]
			gain_pot_load_out   <= boot_reg | (wr_param && register_index == IDX_HW_OFFSET_TRIM)
			                       | (cal_step & cal_ctrl_reg[CTL_GAIN_CAL]); // [R2]
			offset_pot_out      <= hw_offset_trim_reg;
			gain_pot_out        <= hw_gain_trim_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Watchdog on process data
	logic [CNT_W-1:0] wdt_cnt_reg;
	logic             wdt_expire;

	assign wdt_expire = mode_config_reg[MODE_WDT_EN] && !pd_cycle
	                    && (wdt_cnt_reg == CNT_W'(WDT_CYCLES - 1)); // [R8] [R25]

	always_ff @(posedge core_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			wdt_cnt_reg <= '0;
		else if (pd_cycle || !mode_config_reg[MODE_WDT_EN])
			wdt_cnt_reg <= '0; // [R25]
		else if (wdt_cnt_reg != CNT_W'(WDT_CYCLES))
			wdt_cnt_reg <= wdt_cnt_reg + 1'b1; // Stops past timeout so it flags once
	end

	////////////////////////////////////////////////////////////////////////////////
	// Output value: process data or the selected switch-on value
	logic [15:0] pd_value;
	logic [15:0] pd_signed;
	logic [15:0] switch_on_value;

	assign switch_on_value = mode_config_reg[MODE_USER_DEFAULT] ? user_default_output_reg
	                                                           : mfr_default_output_reg; // [R11]

	// Sign-magnitude conversion, then optional absolute value
	always_comb
	begin
		if (mode_config_reg[MODE_SIGN_MAG] && ctrl_data_word_in[15])
			pd_signed = 16'h0000 - {1'b0, ctrl_data_word_in[14:0]}; // [R9]
		else
			pd_signed = ctrl_data_word_in;
		if (mode_config_reg[MODE_ABS_VALUE] && pd_signed[15])
			pd_value = (pd_signed == 16'h8000) ? 16'h7FFF : 16'h0000 - pd_signed; // [R10]
		else
			pd_value = pd_signed;
	end

	always_ff @(posedge core_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			output_value_out   <= 16'h0000;
			default_active_out <= 1'b1;
		end
		else if (pd_cycle)
		begin
			output_value_out   <= pd_value;
			default_active_out <= 1'b0;
		end
		else if (boot_reg || wdt_expire)
		begin
			output_value_out   <= switch_on_value; // [R4] [R13]
			default_active_out <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register read multiplexer
	logic [15:0] read_value;

	always_comb
	begin
		unique case (register_index)
			IDX_HW_OFFSET_TRIM:    read_value = {8'h00, hw_offset_trim_reg};
			IDX_HW_GAIN_TRIM:      read_value = {8'h00, hw_gain_trim_reg};
			IDX_MFR_SCALE_OFFSET:  read_value = mfr_scale_offset_reg;
			IDX_MFR_SCALE_GAIN:    read_value = mfr_scale_gain_reg;
			IDX_MFR_DEFAULT_OUT:   read_value = mfr_default_output_reg;
			IDX_UNLOCK_KEY:        read_value = unlocked ? unlock_key_reg : 16'h0000; // [R6]
			IDX_MODE_CONFIG:       read_value = mode_config_reg;
			IDX_USER_SCALE_OFFSET: read_value = user_scale_offset_reg;
			IDX_USER_SCALE_GAIN:   read_value = user_scale_gain_reg;
			IDX_USER_DEFAULT_OUT:  read_value = user_default_output_reg;
			default:               read_value = 16'h0000;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Answer to the coupler: status byte and data word, one cycle after the request
	always_ff @(posedge core_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			cycle_done_out          <= 1'b0;
			channel_status_byte_out <= 8'h00;
			stat_data_word_out      <= 16'h0000;
		end
		else
		begin
			cycle_done_out <= cycle_valid_in; // [R22]
			if (wr_cycle)
			begin
				channel_status_byte_out <= channel_control_byte_in & 8'hBF; // [R24]
				stat_data_word_out      <= 16'h0000; // [R24]
			end
			else if (reg_cycle)
			begin
				channel_status_byte_out <= channel_control_byte_in; // [R23]
				stat_data_word_out      <= read_value; // [R19]
			end
			else if (pd_cycle)
			begin
				channel_status_byte_out <= STATUS_PROCESS; // [R17]
				stat_data_word_out      <= 16'h0000;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Parameter outputs for the scaling path
	always_ff @(posedge core_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			mode_config_out       <= RST_MODE_CONFIG;
			mfr_scale_offset_out  <= RST_MFR_OFFSET;
			mfr_scale_gain_out    <= RST_MFR_GAIN;
			user_scale_offset_out <= RST_USER_OFFSET;
			user_scale_gain_out   <= RST_USER_GAIN;
			unlocked_out          <= 1'b0;
		end
		else
		begin
			mode_config_out       <= mode_config_reg;
			mfr_scale_offset_out  <= mfr_scale_offset_reg;
			mfr_scale_gain_out    <= mfr_scale_gain_reg;
			user_scale_offset_out <= user_scale_offset_reg; // [R12]
			user_scale_gain_out   <= user_scale_gain_reg; // [R12]
			unlocked_out          <= unlocked;
		end
	end

endmodule // aopra_channel

// File: aopra_channel_props.sv
// Assertion checker of the channel register access ports
`timescale 1ns/1ns
module aopra_channel_props
	import aopra_pkg::*;
#(
	parameter int WDT_CYCLES = WDT_CYC
)(
	input wire logic        core_clk_in,
	input wire logic        rstn_in,
	input wire logic        cycle_valid_in,
	input wire logic [7:0]  channel_control_byte_in,
	input wire logic [15:0] ctrl_data_word_in,
	input wire logic        cycle_done_out,
	input wire logic [7:0]  channel_status_byte_out,
	input wire logic [15:0] stat_data_word_out,
	input wire logic [15:0] output_value_out,
	input wire logic        default_active_out,
	input wire logic        offset_pot_load_out,
	input wire logic        gain_pot_load_out,
	input wire logic [15:0] mode_config_out,
	input wire logic        unlocked_out
);
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (!rstn_in);
	logic [31:0] idle_cnt_reg;
	////////////////////////////////////////
	// Cycles since the last process cycle while the watchdog is on
	always_ff @(posedge core_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			idle_cnt_reg <= 32'h0;
		else if ((cycle_valid_in && !channel_control_byte_in[CTL_REG_MODE]) || !mode_config_out[MODE_WDT_EN])
			idle_cnt_reg <= 32'h0;
		else if (idle_cnt_reg < 32'h1000)
			idle_cnt_reg <= idle_cnt_reg + 32'h1;
	end
	answer_timing_a: assert property (cycle_valid_in |=> cycle_done_out)
		else $error("no answer one cycle after a request");
	no_stray_done_a: assert property (!cycle_valid_in |=> !cycle_done_out)
		else $error("answer without a request");
	read_echo_a: assert property (cycle_valid_in && channel_control_byte_in[7:6] == 2'h2
		|=> channel_status_byte_out == $past(channel_control_byte_in)) else $error("read status not echoed");
	write_ack_a: assert property (cycle_valid_in && channel_control_byte_in[7:6] == 2'h3
		|=> channel_status_byte_out == ($past(channel_control_byte_in) & 8'hBF)) else $error("bad write status");
	process_status_a: assert property (cycle_valid_in && !channel_control_byte_in[7]
		|=> channel_status_byte_out == STATUS_PROCESS) else $error("process status not empty");
	trim_load_a: assert property (cycle_valid_in && channel_control_byte_in == 8'hD1 && unlocked_out
		|-> ##[1:3] (offset_pot_load_out && gain_pot_load_out)) else $error("pots not loaded");
	key_unlock_a: assert property (cycle_valid_in && channel_control_byte_in == 8'hDF
		|-> ##2 (unlocked_out == ($past(ctrl_data_word_in, 2) == UNLOCK_CODE))) else $error("lock state wrong");
	key_read_a: assert property (cycle_valid_in && channel_control_byte_in == 8'h9F && !cycle_done_out
		|=> stat_data_word_out == ($past(unlocked_out) ? UNLOCK_CODE : 16'h0000)) else $error("key readback wrong");
	mode_reserved_a: assert property ((mode_config_out & ~MODE_WRITABLE_MASK) == 16'h0000)
		else $error("reserved mode bits changed");
	process_value_a: assert property (cycle_valid_in && !channel_control_byte_in[7]
		&& !mode_config_out[MODE_SIGN_MAG] && !mode_config_out[MODE_ABS_VALUE]
		|=> output_value_out == $past(ctrl_data_word_in) && !default_active_out) else $error("output not applied");
	watchdog_timeout_a: assert property (idle_cnt_reg == WDT_CYCLES + 1 |-> default_active_out)
		else $error("switch-on value missing after timeout");
endmodule // aopra_channel_props
bind aopra_channel aopra_channel_props #(.WDT_CYCLES(WDT_CYCLES)) props_u (
	.core_clk_in(core_clk_in), .rstn_in(rstn_in), .cycle_valid_in(cycle_valid_in),
	.channel_control_byte_in(channel_control_byte_in), .ctrl_data_word_in(ctrl_data_word_in),
	.cycle_done_out(cycle_done_out), .channel_status_byte_out(channel_status_byte_out),
	.stat_data_word_out(stat_data_word_out), .output_value_out(output_value_out),
	.default_active_out(default_active_out), .offset_pot_load_out(offset_pot_load_out),
	.gain_pot_load_out(gain_pot_load_out), .mode_config_out(mode_config_out), .unlocked_out(unlocked_out));

// File: aopra_channel_test.sv
// Self-checking bench of the channel register access
`timescale 1ns/1ns
module aopra_channel_test
	import aopra_pkg::*;
;
	localparam int WDT = 40;
	localparam logic [5:0] RIDX [12] = '{6'h11, 6'h12, 6'h13, 6'h14, 6'h15, 6'h1F, 6'h20, 6'h21, 6'h22, 6'h23, 6'h05, 6'h3F};
	localparam logic [15:0] RVAL [12] = '{16'h0080, 16'h0080, 16'h0000, 16'h0020, 16'h0000, 16'h0000, 16'h0006,
		16'h0000, 16'h0100, 16'h0000, 16'h0000, 16'h0000};
	localparam logic [5:0] PIDX [6] = '{6'h13, 6'h14, 6'h15, 6'h21, 6'h22, 6'h23};
	localparam logic [15:0] PMODE [5] = '{16'h0006, 16'h000E, 16'h0026, 16'h0026, 16'h0026};
	localparam logic [15:0] PIN [5] = '{16'h1234, 16'h8005, 16'h8000, 16'h7FFF, 16'hFFFE};
	localparam logic [15:0] POUT [5] = '{16'h1234, 16'hFFFB, 16'h7FFF, 16'h7FFF, 16'h0002};
	localparam logic [15:0] WMODE [3] = '{16'h0106, 16'h0006, 16'h0002};
	localparam logic [15:0] WOUT [3] = '{16'hA505, 16'hA502, 16'h1111};
	logic        core_clk_in, rstn_in, send, reply_valid, valid, done, dflt, off_ld, gain_ld, save;
	logic [7:0]  ctrl, stat, off_pot, gain_pot;
	logic [15:0] word, rdata, outv, sc [4];
	logic [23:0] image, reply;
	int          n_mismatch = 0, num_checks = 0, n_off = 0, n_gain = 0, n_save = 0, a, b, c, d, s, i;
	////////////////////////////////////////
	// Channel under test and the coupler that feeds it
	aopra_channel #(.WDT_CYCLES(WDT), .STEP_SLOW_CYCLES(200), .STEP_FAST_CYCLES(20), .HW_TRIM_RESET(8'h80)) dut_u (
		.core_clk_in(core_clk_in), .rstn_in(rstn_in), .cycle_valid_in(valid), .channel_control_byte_in(ctrl),
		.ctrl_data_word_in(word), .cycle_done_out(done), .channel_status_byte_out(stat), .stat_data_word_out(rdata),
		.output_value_out(outv), .default_active_out(dflt), .offset_pot_out(off_pot), .offset_pot_load_out(off_ld),
		.gain_pot_out(gain_pot), .gain_pot_load_out(gain_ld), .mode_config_out(), .mfr_scale_offset_out(sc[0]),
		.mfr_scale_gain_out(sc[1]), .user_scale_offset_out(sc[2]), .user_scale_gain_out(sc[3]), .unlocked_out(),
		.save_req_out(save));
	aopra_coupler_model coupler_u (.core_clk_in(core_clk_in), .rstn_in(rstn_in), .send_in(send), .image_in(image),
		.cycle_done_in(done), .status_byte_in(stat), .data_word_in(rdata), .cycle_valid_out(valid),
		.control_byte_out(ctrl), .data_word_out(word), .reply_image_out(reply), .reply_valid_out(reply_valid));
	// Clock
	initial
	begin
		core_clk_in = 1'b0;
		forever #2 core_clk_in = ~core_clk_in;
	end
	// Tally pot load and save pulses
	always @(posedge core_clk_in)
	begin
		n_off <= n_off + int'(off_ld === 1'b1);
		n_gain <= n_gain + int'(gain_ld === 1'b1);
		n_save <= n_save + int'(save === 1'b1);
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("unexpected value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic conclude;
		if (n_mismatch == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// One channel cycle through the coupler, waiting for its answer
	task automatic xfer(input logic [7:0] cb, input logic [15:0] w);
		int k;
		send <= 1'b1;
		image <= {w, cb};
		@(posedge core_clk_in);
		send <= 1'b0;
		for (k = 0; k < 20 && reply_valid !== 1'b1; k++)
			@(posedge core_clk_in);
		if (reply_valid !== 1'b1)
		begin
			n_mismatch++;
			$display("unexpected hang at %0t: no answer", $time);
			conclude();
		end
	endtask
	task automatic wr(input logic [5:0] idx, input logic [15:0] v);
		xfer({2'h3, idx}, v);
		chk(reply[15:0], {8'h00, 2'h2, idx});
	endtask
	task automatic rd(input logic [5:0] idx, input logic [15:0] exp);
		xfer({2'h2, idx}, 16'h0000);
		chk({8'h00, reply[7:0]}, {8'h00, 2'h2, idx});
		chk(reply[23:8], exp);
	endtask
	task automatic proc(input logic [7:0] cb, input logic [15:0] w, input logic [15:0] exp);
		xfer(cb, w);
		chk(reply[15:0], {8'h00, STATUS_PROCESS});
		chk(outv, exp);
	endtask
	// Run a calibration window and count the load pulses of each pot
	task automatic cal(input logic [7:0] cb, input int cyc, output int n_o, output int n_g);
		int o, g;
		o = n_off;
		g = n_gain;
		proc(cb, 16'h1111, 16'h1111);
		repeat (cyc) @(posedge core_clk_in);
		proc(8'h00, 16'h1111, 16'h1111);
		repeat (3) @(posedge core_clk_in);
		n_o = n_off - o;
		n_g = n_gain - g;
	endtask
	// Main sequence
	initial
	begin
		rstn_in = 1'b0;
		send = 1'b0;
		image = 24'h000000;
		repeat (10) @(posedge core_clk_in);
		rstn_in <= 1'b1;
		repeat (2) @(posedge core_clk_in);
		chk({15'h0000, dflt}, 16'h0001);
		chk({off_pot, gain_pot}, 16'h8080);
		for (i = 0; i < 12; i++)
			rd(RIDX[i], RVAL[i]);
		chk(16'(n_off + n_gain), 16'h0002);
		wr(IDX_USER_SCALE_GAIN, 16'h0200);
		rd(IDX_USER_SCALE_GAIN, 16'h0100);
		rd(IDX_UNLOCK_KEY, 16'h0000);
		wr(IDX_UNLOCK_KEY, 16'h1235);
		rd(IDX_UNLOCK_KEY, 16'h1235);
		wr(IDX_MODE_CONFIG, 16'hFFFF);
		rd(IDX_MODE_CONFIG, 16'h012F);
		for (i = 0; i < 6; i++)
		begin
			wr(PIDX[i], 16'hA500 + 16'(i));
			rd(PIDX[i], 16'hA500 + 16'(i));
		end
		for (i = 0; i < 4; i++)
			chk(sc[i], 16'hA500 + 16'(i + i / 2));
		wr(IDX_HW_GAIN_TRIM, 16'h0055);
		wr(IDX_HW_OFFSET_TRIM, 16'h0033);
		rd(IDX_HW_OFFSET_TRIM, 16'h0033);
		chk({off_pot, gain_pot}, 16'h3355);
		for (i = 0; i < 5; i++)
		begin
			wr(IDX_MODE_CONFIG, PMODE[i]);
			proc(8'h00, PIN[i], POUT[i]);
		end
		for (i = 0; i < 3; i++)
		begin
			wr(IDX_MODE_CONFIG, WMODE[i]);
			proc(8'h00, 16'h1111, 16'h1111);
			repeat (WDT + 5) @(posedge core_clk_in);
			chk(outv, WOUT[i]);
			chk({15'h0000, dflt}, {15'h0000, WOUT[i] != 16'h1111});
		end
		cal(8'h4E, 450, a, b);
		chk({15'h0000, a inside {[21:23]} && b == 0}, 16'h0001);
		cal(8'h51, 450, c, d);
		chk({15'h0000, d inside {[2:3]} && c == 0}, 16'h0001);
		chk({off_pot, gain_pot}, {8'h33 + 8'(a), 8'h55 - 8'(d)});
		s = n_save;
		wr(IDX_UNLOCK_KEY, 16'h0000);
		repeat (2) @(posedge core_clk_in);
		chk(16'(n_save - s), 16'h0001);
		cal(8'h4E, 100, a, b);
		chk(16'(a), 16'h0000);
		rd(IDX_UNLOCK_KEY, 16'h0000);
		conclude();
	end
endmodule // aopra_channel_test

// File: aopra_coupler_model.sv
// Bus coupler model relaying controller channel images to one channel
`timescale 1ns/1ns
module aopra_coupler_model
	import aopra_pkg::*;
(
	input  wire logic        core_clk_in,
	input  wire logic        rstn_in,
	input  wire logic        send_in,
	input  wire logic [23:0] image_in,
	input  wire logic        cycle_done_in,
	input  wire logic [7:0]  status_byte_in,
	input  wire logic [15:0] data_word_in,
	output logic             cycle_valid_out,
	output logic [7:0]       control_byte_out,
	output logic [15:0]      data_word_out,
	output logic [23:0]      reply_image_out,
	output logic             reply_valid_out
);
	////////////////////////////////////////
	// Present one image: control byte lowest, word in the next two bytes; scramble lines between
	always_ff @(posedge core_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			cycle_valid_out <= 1'b0;
			control_byte_out <= 8'h00;
			data_word_out <= 16'h0000;
		end
		else
		begin
			cycle_valid_out <= send_in;
			control_byte_out <= send_in ? image_in[7:0] : ~control_byte_out;
			data_word_out <= send_in ? image_in[23:8] : ~data_word_out;
		end
	end
	// Collect the answer image when the channel acknowledges
	always_ff @(posedge core_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			reply_image_out <= 24'h000000;
		else if (cycle_done_in)
			reply_image_out <= {data_word_in, status_byte_in};
	end
	// Flag a fresh answer for one cycle
	always_ff @(posedge core_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			reply_valid_out <= 1'b0;
		else
			reply_valid_out <= cycle_done_in;
	end
endmodule // aopra_coupler_model

// File: aopra_pkg.sv
// Constants and register map of the analog output parameter register bank
package aopra_pkg;
	// Register indices carried in the channel control byte
	localparam logic [5:0] IDX_HW_OFFSET_TRIM   = 6'h11;
	localparam logic [5:0] IDX_HW_GAIN_TRIM     = 6'h12;
	localparam logic [5:0] IDX_MFR_SCALE_OFFSET = 6'h13;
	localparam logic [5:0] IDX_MFR_SCALE_GAIN   = 6'h14;
	localparam logic [5:0] IDX_MFR_DEFAULT_OUT  = 6'h15;
	localparam logic [5:0] IDX_UNLOCK_KEY       = 6'h1F;
	localparam logic [5:0] IDX_MODE_CONFIG      = 6'h20;
	localparam logic [5:0] IDX_USER_SCALE_OFFSET = 6'h21;
	localparam logic [5:0] IDX_USER_SCALE_GAIN  = 6'h22;
	localparam logic [5:0] IDX_USER_DEFAULT_OUT = 6'h23;

	// Reset values
	localparam logic [7:0]  RST_HW_TRIM        = 8'h80;
	localparam logic [15:0] RST_MFR_OFFSET     = 16'h0000;
	localparam logic [15:0] RST_MFR_GAIN       = 16'h0020;
	localparam logic [15:0] RST_MFR_DEFAULT    = 16'h0000;
	localparam logic [15:0] RST_MODE_CONFIG    = 16'h0006;
	localparam logic [15:0] RST_USER_OFFSET    = 16'h0000;
	localparam logic [15:0] RST_USER_GAIN      = 16'h0100;
	localparam logic [15:0] RST_USER_DEFAULT   = 16'h0000;
	localparam logic [15:0] UNLOCK_CODE        = 16'h1235;
	localparam logic [15:0] MODE_WRITABLE_MASK = 16'h012F;

	// Mode configuration fields
	localparam int MODE_USER_SCALE  = 0;
	localparam int MODE_MFR_SCALE   = 1;
	localparam int MODE_WDT_EN      = 2;
	localparam int MODE_SIGN_MAG    = 3;
	localparam int MODE_ABS_VALUE   = 5;
	localparam int MODE_USER_DEFAULT = 8;

	// Channel control byte fields
	localparam int CTL_REG_MODE   = 7;
	localparam int CTL_WRITE      = 6;
	localparam int CTL_COMP_EN    = 6;
	localparam int CTL_GAIN_CAL   = 4;
	localparam int CTL_OFFSET_CAL = 3;
	localparam int CTL_FAST       = 2;
	localparam int CTL_UP         = 1;
	localparam int CTL_DOWN       = 0;
	localparam logic [7:0] STATUS_PROCESS = 8'h00;

	// Timing: times in ms, clock in kHz, counts in cycles
	localparam int CLK_KHZ      = 250000;
	localparam int WDT_MS       = 100;
	localparam int STEP_SLOW_MS = 1000;
	localparam int STEP_FAST_MS = 50;
	localparam int WDT_CYC       = WDT_MS * CLK_KHZ;
	localparam int STEP_SLOW_CYC = STEP_SLOW_MS * CLK_KHZ;
	localparam int STEP_FAST_CYC = STEP_FAST_MS * CLK_KHZ;
	localparam int CNT_W         = 28;
endpackage : aopra_pkg
